// ---- hdl/bod_pkg.sv ----
package bod_pkg;

  // widths
  localparam int INST_W = 14;
  localparam int DATA_W = 8;
  localparam int FADR_W = 7;
  localparam int PC_W   = 13;
  localparam int BADR_W = 4;
  localparam int BDAT_W = 16;
  localparam int CNT_W  = 16;

  // instruction field positions
  localparam int GRP_HI  = 13;
  localparam int GRP_LO  = 12;
  localparam int OPC_HI  = 11;
  localparam int OPC_LO  = 8;
  localparam int DST_BIT = 7;
  localparam int FAD_HI  = 6;
  localparam int NIB_HI  = 3;

  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [3:0] NIB_ZERO = 4'h0;

  // byte-oriented opcodes
  localparam logic [3:0] OPC_ZERO  = 4'h0;
  localparam logic [3:0] OPC_CLR   = 4'h1;
  localparam logic [3:0] OPC_DEC   = 4'h3;
  localparam logic [3:0] OPC_IOR   = 4'h4;
  localparam logic [3:0] OPC_AND   = 4'h5;
  localparam logic [3:0] OPC_ADD   = 4'h7;
  localparam logic [3:0] OPC_MOV   = 4'h8;
  localparam logic [3:0] OPC_COM   = 4'h9;
  localparam logic [3:0] OPC_INC   = 4'hA;
  localparam logic [3:0] OPC_DECSZ = 4'hB;
  localparam logic [3:0] OPC_ROL   = 4'hD;
  localparam logic [3:0] OPC_INCSZ = 4'hF;

  // register map
  localparam logic [BADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [BADR_W-1:0] REG_STAT = 4'h4;
  localparam logic [BADR_W-1:0] REG_ICNT = 4'h8;
  localparam logic [BADR_W-1:0] REG_SCNT = 4'hC;
  localparam logic              CTRL_RST = 1'b1;
  localparam int                STAT_OP_LO = 4;

  // alu operations, one-hot
  typedef enum logic [10:0] {
    BOD_OP_NOP = 11'h001,
    BOD_OP_ADD = 11'h002,
    BOD_OP_AND = 11'h004,
    BOD_OP_CLR = 11'h008,
    BOD_OP_COM = 11'h010,
    BOD_OP_DEC = 11'h020,
    BOD_OP_INC = 11'h040,
    BOD_OP_IOR = 11'h080,
    BOD_OP_MOV = 11'h100,
    BOD_OP_STW = 11'h200,
    BOD_OP_ROL = 11'h400
  } bod_op_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } bod_flags_t;

  typedef struct packed {
    bod_op_t    op;
    logic       dest_file;
    bod_flags_t upd;
    logic       skip_op;
    logic       ours;
  } bod_dec_t;

  typedef enum logic [1:0] {
    BOD_ST_RUN  = 2'h1,
    BOD_ST_KILL = 2'h2
  } bod_state_t;

endpackage

// ---- hdl/bod_alu.sv ----
`timescale 1ns/1ns
module bod_alu
  import bod_pkg::*;
(
  input  bod_pkg::bod_op_t             op,
  input  logic [bod_pkg::DATA_W-1:0]   w_val,
  input  logic [bod_pkg::DATA_W-1:0]   file_val,
  input  logic                         carry_in,
  output logic [bod_pkg::DATA_W-1:0]   res,
  output bod_pkg::bod_flags_t          flg
);

  logic [DATA_W:0] sum;
  logic [4:0]      nib_sum;

  // carries of the add
  assign sum     = {1'b0, w_val} + {1'b0, file_val};
  assign nib_sum = {1'b0, w_val[NIB_HI:0]} + {1'b0, file_val[NIB_HI:0]};

  // result per operation
  always_comb
  begin
    res = file_val;
    flg.c = 1'b0;
    flg.dc = 1'b0;
    unique case (op)
      BOD_OP_ADD:
      begin
        res = sum[DATA_W-1:0];
        flg.c = sum[DATA_W];
        flg.dc = nib_sum[4];
      end
      BOD_OP_AND: res = w_val & file_val;
      BOD_OP_CLR: res = '0;
      BOD_OP_COM: res = ~file_val;
      BOD_OP_DEC: res = file_val - 8'h01;
      BOD_OP_INC: res = file_val + 8'h01;
      BOD_OP_IOR: res = w_val | file_val;
      BOD_OP_STW: res = w_val;
      BOD_OP_ROL:
      begin
        res = {file_val[DATA_W-2:0], carry_in};
        flg.c = file_val[DATA_W-1];
      end
      default: res = file_val;
    endcase
    flg.z = (res == '0);
  end

endmodule

// ---- hdl/bod_decoder.sv ----
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module bod_decoder
  import bod_pkg::*;
(
  input  logic                         ref_clk,
  input  logic                         rst_n,
  input  logic [bod_pkg::BADR_W-1:0]   bus_addr,
  input  logic [bod_pkg::BDAT_W-1:0]   bus_wdata,
  input  logic                         bus_wr,
  input  logic                         bus_rd,
  output logic [bod_pkg::BDAT_W-1:0]   bus_rdata_q,
  input  logic                         inst_vld,
  input  logic [bod_pkg::INST_W-1:0]   inst,
  input  logic [bod_pkg::DATA_W-1:0]   w_val,
  input  logic [bod_pkg::DATA_W-1:0]   file_val,
  input  logic                         carry_val,
  input  logic                         irq_enter,
  input  logic [bod_pkg::PC_W-1:0]     ret_pc,
  output logic [bod_pkg::DATA_W-1:0]   res_q,
  output logic [bod_pkg::FADR_W-1:0]   file_addr_q,
  output logic                         file_we_q,
  output logic                         w_we_q,
  output bod_pkg::bod_flags_t          flags_q,
  output bod_pkg::bod_flags_t          flag_we_q,
  output logic                         skip_q,
  output logic                         other_vld_q,
  output logic [bod_pkg::INST_W-1:0]   other_inst_q,
  output logic                         push_q,
  output logic [bod_pkg::PC_W-1:0]     push_pc_q
);

  // byte-group decode of one word
  function automatic bod_dec_t decode_byte(input logic [INST_W-1:0] iw);
    bod_dec_t d;
    d = '0;
    d.op = BOD_OP_NOP;
    d.dest_file = iw[DST_BIT];
    if (iw[GRP_HI:GRP_LO] == GRP_BYTE)
    begin
      d.ours = 1'b1;
      case (iw[OPC_HI:OPC_LO])
        OPC_ADD:
        begin
          d.op = BOD_OP_ADD;
          d.upd = '{c: 1'b1, dc: 1'b1, z: 1'b1};
        end
        OPC_AND:
        begin
          d.op = BOD_OP_AND;
          d.upd.z = 1'b1;
        end
        OPC_CLR:
        begin
          d.op = BOD_OP_CLR;
          d.upd.z = 1'b1;
        end
        OPC_COM:
        begin
          d.op = BOD_OP_COM;
          d.upd.z = 1'b1;
        end
        OPC_DEC:
        begin
          d.op = BOD_OP_DEC;
          d.upd.z = 1'b1;
        end
        OPC_DECSZ:
        begin
          d.op = BOD_OP_DEC;
          d.skip_op = 1'b1;
        end
        OPC_INC:
        begin
          d.op = BOD_OP_INC;
          d.upd.z = 1'b1;
        end
        OPC_INCSZ:
        begin
          d.op = BOD_OP_INC;
          d.skip_op = 1'b1;
        end
        OPC_IOR:
        begin
          d.op = BOD_OP_IOR;
          d.upd.z = 1'b1;
        end
        OPC_MOV:
        begin
          d.op = BOD_OP_MOV;
          d.upd.z = 1'b1;
        end
        OPC_ROL:
        begin
          d.op = BOD_OP_ROL;
          d.upd.c = 1'b1;
        end
        OPC_ZERO:
        begin
          if (iw[DST_BIT])
            d.op = BOD_OP_STW;
          else if (iw[NIB_HI:0] == NIB_ZERO)
            d.op = BOD_OP_NOP;
          else
            d.ours = 1'b0;
        end
        default: d.ours = 1'b0;
      endcase
    end
    return d;
  endfunction

  bod_state_t            state_q, state_d;
  logic                  en_q;
  bod_op_t               last_op_q;
  logic [CNT_W-1:0]      icnt_q, icnt_d;
  logic [CNT_W-1:0]      scnt_q, scnt_d;
  bod_dec_t              dec;
  logic [DATA_W-1:0]     alu_res;
  bod_flags_t            alu_flg;
  logic                  take;
  logic                  exec;
  logic                  writes;
  logic                  skip_hit;
  logic                  pass;
  logic [3:0]            opc;
  logic [BDAT_W-1:0]     rd_val;
  logic [BDAT_W-1:0]     stat_val;

  // decode and qualify the word
  assign dec      = decode_byte(inst);
  assign opc      = inst[OPC_HI:OPC_LO];
  assign take     = inst_vld && !irq_enter;
  assign exec     = take && en_q && dec.ours && (state_q == BOD_ST_RUN);
  assign writes   = exec && (dec.op != BOD_OP_NOP);
  assign skip_hit = exec && dec.skip_op && alu_flg.z;
  assign pass     = take && (state_q == BOD_ST_RUN) && !(en_q && dec.ours);

  bod_alu u_alu (
    .op       (dec.op),
    .w_val    (w_val),
    .file_val (file_val),
    .carry_in (carry_val),
    .res      (alu_res),
    .flg      (alu_flg)
  );

  // skip state: the word after a met skip is thrown away
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      BOD_ST_RUN:  if (skip_hit) state_d = BOD_ST_KILL;
      BOD_ST_KILL: if (take) state_d = BOD_ST_RUN;
      default:     state_d = BOD_ST_RUN;
    endcase
  end

  // counters, a bus write to a counter's offset clears that counter
  assign icnt_d = (bus_wr && bus_addr == REG_ICNT) ? '0 :
                  take ? icnt_q + 16'h0001 : icnt_q;
  assign scnt_d = (bus_wr && bus_addr == REG_SCNT) ? '0 :
                  skip_hit ? scnt_q + 16'h0001 : scnt_q;

  // register read selection
  assign stat_val = {1'b0, last_op_q, 2'b00, en_q, state_q == BOD_ST_KILL};
  assign rd_val   = (bus_addr == REG_CTRL) ? {{(BDAT_W-1){1'b0}}, en_q} :
                    (bus_addr == REG_STAT) ? stat_val :
                    (bus_addr == REG_ICNT) ? icnt_q :
                    (bus_addr == REG_SCNT) ? scnt_q : '0;

  // control and bus registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= BOD_ST_RUN;
      en_q        <= CTRL_RST;
      last_op_q   <= BOD_OP_NOP;
      icnt_q      <= '0;
      scnt_q      <= '0;
      bus_rdata_q <= '0;
    end
    else
    begin
      state_q     <= state_d;
      icnt_q      <= icnt_d;
      scnt_q      <= scnt_d;
      bus_rdata_q <= bus_rd ? rd_val : '0;
      if (bus_wr && bus_addr == REG_CTRL)
        en_q <= bus_wdata[0];
      if (exec)
        last_op_q <= dec.op;
    end
  end

  // execution outputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_q        <= '0;
      file_addr_q  <= '0;
      file_we_q    <= 1'b0;
      w_we_q       <= 1'b0;
      flags_q      <= '0;
      flag_we_q    <= '0;
      skip_q       <= 1'b0;
      other_vld_q  <= 1'b0;
      other_inst_q <= '0;
    end
    else
    begin
      res_q        <= alu_res;
      file_addr_q  <= inst[FAD_HI:0];
      file_we_q    <= writes && dec.dest_file;
      w_we_q       <= writes && !dec.dest_file;
      flags_q      <= alu_flg;
      flag_we_q    <= exec ? dec.upd : '0;
      skip_q       <= skip_hit;
      other_vld_q  <= pass;
      other_inst_q <= inst;
    end
  end

  // interrupt entry pushes the return address and nothing else
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_q    <= 1'b0;
      push_pc_q <= '0;
    end
    else
    begin
      push_q    <= irq_enter;
      push_pc_q <= ret_pc;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_irq_push;
    irq_enter |=> push_q && push_pc_q == $past(ret_pc) && !w_we_q && !file_we_q
      && flag_we_q == '0;
  endproperty
  a_irq_push: assert property (p_irq_push) else $error("irq entry saved more than pc");

  property p_add;
    exec && opc == OPC_ADD |=> flag_we_q == 3'b111 && res_q == $past(w_val + file_val);
  endproperty
  a_add: assert property (p_add) else $error("add decode wrong");

  property p_and;
    exec && opc == OPC_AND |=> flag_we_q == 3'b001 && res_q == $past(w_val & file_val);
  endproperty
  a_and: assert property (p_and) else $error("and decode wrong");

  property p_clr;
    exec && opc == OPC_CLR && inst[DST_BIT] |=> file_we_q && res_q == '0 && flags_q.z
      && flag_we_q == 3'b001;
  endproperty
  a_clr: assert property (p_clr) else $error("clear decode wrong");

  property p_zonly;
    exec && (opc == OPC_COM || opc == OPC_DEC || opc == OPC_INC || opc == OPC_IOR)
      |=> flag_we_q == 3'b001 && (file_we_q || w_we_q);
  endproperty
  a_zonly: assert property (p_zonly) else $error("zero-only flag mask wrong");

  property p_skipop;
    exec && (opc == OPC_DECSZ || opc == OPC_INCSZ) |=> flag_we_q == '0
      && skip_q == (res_q == '0);
  endproperty
  a_skipop: assert property (p_skipop) else $error("skip op changed flags");

  property p_mov;
    exec && opc == OPC_MOV |=> flag_we_q == 3'b001 && res_q == $past(file_val);
  endproperty
  a_mov: assert property (p_mov) else $error("move decode wrong");

  property p_stw;
    exec && opc == OPC_ZERO && inst[DST_BIT] |=> file_we_q && !w_we_q
      && res_q == $past(w_val) && flag_we_q == '0;
  endproperty
  a_stw: assert property (p_stw) else $error("store w decode wrong");

  property p_nop;
    exec && opc == OPC_ZERO && !inst[DST_BIT] |=> !file_we_q && !w_we_q && flag_we_q == '0;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

  property p_rol;
    exec && opc == OPC_ROL |=> flag_we_q == 3'b100
      && res_q == $past({file_val[DATA_W-2:0], carry_val});
  endproperty
  a_rol: assert property (p_rol) else $error("rotate decode wrong");

  property p_dest;
    writes |=> file_we_q == $past(inst[DST_BIT]) && w_we_q == !$past(inst[DST_BIT])
      && file_addr_q == $past(inst[FAD_HI:0]);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_kill;
    state_q == BOD_ST_KILL && take |=> !file_we_q && !w_we_q && flag_we_q == '0
      && !other_vld_q;
  endproperty
  a_kill: assert property (p_kill) else $error("skipped word was executed");

  // a met skip must arm the discard of the next taken word
  property p_skip_arm;
    skip_q |-> state_q == BOD_ST_KILL;
  endproperty
  a_skip_arm: assert property (p_skip_arm) else $error("met skip did not arm discard");

  property p_other;
    take && state_q == BOD_ST_RUN && inst[GRP_HI:GRP_LO] != GRP_BYTE |=> other_vld_q
      && other_inst_q == $past(inst) && !file_we_q && !w_we_q;
  endproperty
  a_other: assert property (p_other) else $error("foreign group not passed on");

  c_skip:  cover property (skip_hit ##1 take);
  c_irq:   cover property (irq_enter ##1 push_q);
  c_other: cover property (pass);
  c_add:   cover property (exec && opc == OPC_ADD && alu_flg.c);

endmodule

// ---- bench/bod_prog_mem.sv ----
`timescale 1ns/1ns
module bod_prog_mem
  import bod_pkg::*;
(
  input  logic                         ref_clk,
  input  logic                         fetch,
  input  logic [3:0]                   pc,
  output logic                         inst_vld,
  output logic [bod_pkg::INST_W-1:0]   inst
);
  logic [INST_W-1:0] rom [16];
  logic [INST_W-1:0] last_q;

  // program image: every byte opcode, a clear to w, a no-operation and two foreign words
  initial
  begin
    rom = '{14'h0785, 14'h0505, 14'h0185, 14'h0103, 14'h0985, 14'h0385, 14'h0B85, 14'h0A05,
            14'h0F85, 14'h0405, 14'h0805, 14'h0085, 14'h0060, 14'h0D85, 14'h2005, 14'h0285};
    last_q = 14'h0000;
  end

  // remember the last word so that a released bus can show its inverse
  always @(posedge ref_clk)
  begin
    if (fetch)
    begin
      last_q <= rom[pc];
    end
  end

  // a word stands only while fetched; the idle bus never repeats stale data
  assign inst_vld = fetch;
  assign inst     = fetch ? rom[pc] : ~last_q;
endmodule

// ---- bench/test_byte_op_instruction_decoder.sv ----
`timescale 1ns/1ns
module test_byte_op_instruction_decoder
  import bod_pkg::*;
;
  logic              ref_clk, rst_n, bus_wr, bus_rd, fetch, irq_enter, carry_val, inst_vld;
  logic              file_we_q, w_we_q, skip_q, other_vld_q, push_q, pend, en;
  logic [BADR_W-1:0] bus_addr;
  logic [BDAT_W-1:0] bus_wdata, bus_rdata_q;
  logic [3:0]        pc;
  logic [INST_W-1:0] inst, other_inst_q;
  logic [DATA_W-1:0] w_val, file_val, res_q;
  logic [PC_W-1:0]   ret_pc, push_pc_q;
  logic [FADR_W-1:0] file_addr_q;
  bod_flags_t        flags_q, flag_we_q;
  logic [52:0]       exp_q;
  int                error_cnt, num_checks, cyc;

  bod_decoder bod_decoder_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q), .inst_vld(inst_vld),
    .inst(inst), .w_val(w_val), .file_val(file_val), .carry_val(carry_val),
    .irq_enter(irq_enter), .ret_pc(ret_pc), .res_q(res_q), .file_addr_q(file_addr_q),
    .file_we_q(file_we_q), .w_we_q(w_we_q), .flags_q(flags_q), .flag_we_q(flag_we_q),
    .skip_q(skip_q), .other_vld_q(other_vld_q), .other_inst_q(other_inst_q),
    .push_q(push_q), .push_pc_q(push_pc_q));

  bod_prog_mem bod_prog_mem_i (
    .ref_clk(ref_clk), .fetch(fetch), .pc(pc), .inst_vld(inst_vld), .inst(inst));

  // clock and hang guard
  initial
  begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // reference decode: {push, file_we, w_we, skip, other, mask, flags, res, addr, pc, word}
  function automatic logic [52:0] model(input logic [13:0] i, input logic [7:0] w,
                                        input logic [7:0] f, input logic c);
    logic [7:0] r;
    logic [2:0] m;
    logic       cy, dcy, k, sk, we;
    r = 8'h00;
    m = 3'h0;
    cy = 1'h0;
    dcy = 1'h0;
    sk = 1'h0;
    k = en && i[GRP_HI:GRP_LO] == GRP_BYTE;
    case (i[OPC_HI:OPC_LO])
      OPC_ZERO:
      begin
        r = w;
        k = k && (i[DST_BIT] || i[NIB_HI:0] == NIB_ZERO);
      end
      OPC_CLR:   m = 3'h1;
      OPC_DEC:   {m, r} = {3'h1, f - 8'h01};
      OPC_IOR:   {m, r} = {3'h1, w | f};
      OPC_AND:   {m, r} = {3'h1, w & f};
      OPC_ADD:
      begin
        {cy, r} = w + f;
        dcy = ({1'h0, w[3:0]} + f[3:0]) > 5'h0F;
        m = 3'h7;
      end
      OPC_MOV:   {m, r} = {3'h1, f};
      OPC_COM:   {m, r} = {3'h1, ~f};
      OPC_INC:   {m, r} = {3'h1, f + 8'h01};
      OPC_DECSZ: {sk, r} = {f == 8'h01, f - 8'h01};
      OPC_ROL:   {m, cy, r} = {3'h4, f, c};
      OPC_INCSZ: {sk, r} = {f == 8'hFF, f + 8'h01};
      default:   k = 1'h0;
    endcase
    m = k ? m : 3'h0;
    we = k && (i[OPC_HI:OPC_LO] != OPC_ZERO || i[DST_BIT]);
    return {1'h0, we && i[DST_BIT], we && !i[DST_BIT], k && sk, !k, m,
            {cy, dcy, r == 8'h00} & m, we ? r : 8'h00, we ? i[6:0] : 7'h00,
            13'h0000, k ? 14'h0000 : i};
  endfunction

  // one instruction cycle: present a word or an interrupt, judge the previous cycle
  task automatic step(input logic v, input logic irq, input logic [3:0] p,
                      input logic [7:0] w, input logic [7:0] f, input logic c);
    logic [52:0] obs;
    @(posedge ref_clk);
    fetch <= v;
    irq_enter <= irq;
    pc <= p;
    w_val <= w;
    file_val <= f;
    carry_val <= c;
    ret_pc <= {p, 9'h0AB};
    #1;
    obs = {push_q, file_we_q, w_we_q, skip_q, other_vld_q, flag_we_q, flags_q & flag_we_q,
           (file_we_q | w_we_q) ? res_q : 8'h00, (file_we_q | w_we_q) ? file_addr_q : 7'h00,
           push_q ? push_pc_q : 13'h0000, other_vld_q ? other_inst_q : 14'h0000};
    check(64'(obs[52:48]), 64'(exp_q[52:48]));
    check(64'(obs[47:42]), 64'(exp_q[47:42]));
    check(64'(obs[41:27]), 64'(exp_q[41:27]));
    check(64'(obs[26:0]), 64'(exp_q[26:0]));
    if (irq)
    begin
      exp_q = {1'h1, 25'h0, p, 9'h0AB, 14'h0000};
    end
    else if (v && pend)
    begin
      exp_q = '0;
      pend = 1'h0;
    end
    else if (v)
    begin
      exp_q = model(bod_prog_mem_i.rom[p], w, f, c);
      pend = exp_q[49];
    end
    else
    begin
      exp_q = '0;
    end
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'h0;
  endtask

  task automatic bus_read(input logic [3:0] a, input logic [15:0] want);
    @(posedge ref_clk);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'h0;
    #1;
    check(64'(bus_rdata_q), 64'(want));
    @(posedge ref_clk);
    #1;
    check(64'(bus_rdata_q), 64'h0);
  endtask

  task automatic t_reset_regs();
    bus_read(REG_CTRL, 16'h0001);
    bus_read(REG_STAT, 16'h0012);
    bus_read(REG_ICNT, 16'h0000);
    bus_read(REG_SCNT, 16'h0000);
    bus_read(4'h2, 16'h0000);
  endtask

  // every word of the image back to back under three operand sets, two skips among them
  task automatic t_all_ops();
    bus_write(REG_ICNT, 16'h0001);
    bus_write(REG_SCNT, 16'h0001);
    for (int p = 0; p < 16; p++) step(1'h1, 1'h0, 4'(p), 8'h3C, 8'hFF, 1'h1);
    for (int p = 0; p < 16; p++) step(1'h1, 1'h0, 4'(p), 8'h3C, 8'h01, 1'h0);
    for (int p = 0; p < 16; p++) step(1'h1, 1'h0, 4'(p), 8'hF8, 8'h08, 1'h1);
    step(1'h0, 1'h0, 4'h0, 8'h00, 8'h00, 1'h0);
    bus_read(REG_ICNT, 16'h0030);
    bus_read(REG_SCNT, 16'h0002);
  endtask

  // interrupt lands while a skip is pending; the discard still falls on the next word
  task automatic t_skip_irq();
    step(1'h1, 1'h0, 4'h6, 8'h3C, 8'h01, 1'h0);
    step(1'h1, 1'h1, 4'h0, 8'h3C, 8'h01, 1'h0);
    step(1'h1, 1'h0, 4'hD, 8'h3C, 8'h81, 1'h1);
    step(1'h1, 1'h0, 4'hD, 8'h3C, 8'h81, 1'h1);
    step(1'h0, 1'h1, 4'h7, 8'h00, 8'h00, 1'h0);
    step(1'h0, 1'h0, 4'h0, 8'h00, 8'h00, 1'h0);
    bus_read(REG_STAT, 16'h4002);
  endtask

  // with decoding off every word is handed on untouched
  task automatic t_disable();
    bus_write(REG_CTRL, 16'h0000);
    en = 1'h0;
    step(1'h1, 1'h0, 4'h0, 8'h3C, 8'h01, 1'h0);
    step(1'h1, 1'h0, 4'hB, 8'h3C, 8'h01, 1'h0);
    step(1'h0, 1'h0, 4'h0, 8'h00, 8'h00, 1'h0);
    bus_read(REG_CTRL, 16'h0000);
    bus_write(REG_CTRL, 16'h0001);
    en = 1'h1;
    step(1'h1, 1'h0, 4'h0, 8'h3C, 8'h01, 1'h0);
    step(1'h0, 1'h0, 4'h0, 8'h00, 8'h00, 1'h0);
  endtask

  // main sequence
  initial
  begin
    {rst_n, bus_wr, bus_rd, fetch, irq_enter, carry_val} = '0;
    {bus_addr, bus_wdata, pc, w_val, file_val, ret_pc} = '0;
    {exp_q, pend, error_cnt, num_checks, cyc} = '0;
    en = 1'h1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_reset_regs();
    t_all_ops();
    t_skip_irq();
    t_disable();
    wrap_up();
  end
endmodule
